// [ist_pkg.sv]
/*
 ist_pkg: constants and carriers for the instruction state timing block.
 assumes one 50 MHz cpu clock; wait counts come from the bus controller.
*/
package ist_pkg;

	// ----------------------------------------------------------------
	// per-cycle state costs
	// ----------------------------------------------------------------
	localparam logic [3:0] IST_S_ONCHIP_FETCH = 4'h2;
	localparam logic [3:0] IST_S_INTERNAL = 4'h1;
	localparam logic [3:0] IST_S_MOD8_WORD = 4'h6;
	localparam logic [3:0] IST_S_MOD8_BYTE = 4'h3;
	localparam logic [3:0] IST_S_MOD16_WORD = 4'h3;
	localparam logic [3:0] IST_S_EXT8_2ST_WORD = 4'h4;
	localparam logic [3:0] IST_S_EXT8_2ST_BYTE = 4'h2;
	localparam logic [3:0] IST_S_EXT8_3ST_WORD = 4'h6;
	localparam logic [3:0] IST_S_EXT8_3ST_BYTE = 4'h3;
	localparam logic [3:0] IST_S_EXT16_2ST_WORD = 4'h2;
	localparam logic [3:0] IST_S_EXT16_3ST_WORD = 4'h3;

	// ----------------------------------------------------------------
	// field widths
	// ----------------------------------------------------------------
	localparam int IST_CNT_W = 3;
	localparam int IST_WAIT_W = 3;
	localparam int IST_TOTAL_W = 10;

	typedef enum logic [2:0] {
		IST_RGN_ONCHIP,
		IST_RGN_MOD8,
		IST_RGN_MOD16,
		IST_RGN_EXT8,
		IST_RGN_EXT16
	} ist_region_e;

	typedef enum logic [1:0] {
		IST_ACC_FETCH,
		IST_ACC_BYTE,
		IST_ACC_WORD
	} ist_acc_e;

	// form of the instruction being timed
	typedef enum logic [2:0] {
		IST_F_REG,
		IST_F_IMM8,
		IST_F_IMM16,
		IST_F_IMM32,
		IST_F_ANDL_REG,
		IST_F_BITMEM,
		IST_F_BCC8,
		IST_F_EXPLICIT
	} ist_form_e;

	typedef struct packed {
		logic [IST_CNT_W-1:0] fetch;
		logic [IST_CNT_W-1:0] branch;
		logic [IST_CNT_W-1:0] stack;
		logic [IST_CNT_W-1:0] byte_acc;
		logic [IST_CNT_W-1:0] word_acc;
		logic [IST_CNT_W-1:0] internal;
	} ist_counts_s;

	// one region descriptor per bus cycle kind: fetch, branch, stack, data
	typedef struct packed {
		ist_region_e region;
		logic three_state;
		logic [IST_WAIT_W-1:0] waits;
	} ist_region_s;

	typedef struct packed {
		ist_region_s fetch;
		ist_region_s branch;
		ist_region_s stack;
		ist_region_s data;
	} ist_map_s;

endpackage : ist_pkg

// [ist_timing.sv]
/*
 ist_timing: computes and sequences the state count of each instruction.
 assumes start requests come from core logic on clk_sys and wait_pulse
 comes synchronously from the bus controller, one pulse per wait state.
*/
`timescale 1ns/1ps

// What this block does
// - total states equal sum of category counts times per-cycle state costs
// - each form but explicit carries fixed counts for all six cycle categories; explicit takes them from explicit_counts
// - per-cycle cost depends on region width and two or three state access
// - on-chip fetch 2, internal 1, 8-bit module 6 or 3, 16-bit module 3
// - external three-state 6+2m or 3+m; two-state 4 or 2
// - fetch counts per form: 1,1,2,3, long and 2, bit-memory 2+1, branch 2
module ist_timing
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic start,
	input wire ist_pkg::ist_form_e form,
	input wire ist_pkg::ist_counts_s explicit_counts,
	input wire ist_pkg::ist_map_s map,
	input wire logic wait_pulse,
	output logic ready,
	output logic busy,
	output logic done,
	output logic [ist_pkg::IST_TOTAL_W-1:0] total_states
);
	import ist_pkg::*;

	// ----------------------------------------------------------------
	// cost and count functions
	// ----------------------------------------------------------------
	// waits are left out of the static cost: the bus reports each wait state live,
	// so a slow 8-bit word access shows its 2m as 2m separate pulses
	function automatic logic [5:0] cyc_cost(input ist_region_s r, input ist_acc_e a);
		logic [5:0] m;
		m = {3'h0, r.waits};
		cyc_cost = 6'h00;
		unique case (r.region)
			IST_RGN_ONCHIP: cyc_cost = {2'h0, IST_S_ONCHIP_FETCH};
			IST_RGN_MOD8: cyc_cost = (a == IST_ACC_BYTE) ? {2'h0, IST_S_MOD8_BYTE}
				: {2'h0, IST_S_MOD8_WORD};
			IST_RGN_MOD16: cyc_cost = {2'h0, IST_S_MOD16_WORD};
			IST_RGN_EXT8:
			begin
				if (!r.three_state)
					cyc_cost = (a == IST_ACC_BYTE) ? {2'h0, IST_S_EXT8_2ST_BYTE}
						: {2'h0, IST_S_EXT8_2ST_WORD};
				else if (a == IST_ACC_BYTE)
					cyc_cost = {2'h0, IST_S_EXT8_3ST_BYTE} + m;
				else
					cyc_cost = {2'h0, IST_S_EXT8_3ST_WORD} + {m[4:0], 1'b0};
			end
			IST_RGN_EXT16: cyc_cost = r.three_state ? {2'h0, IST_S_EXT16_3ST_WORD} + m
				: {2'h0, IST_S_EXT16_2ST_WORD};
			default: cyc_cost = 6'h00;
		endcase
	endfunction : cyc_cost

	// static part excludes waits: those are counted live from wait_pulse
	function automatic ist_region_s no_wait(input ist_region_s r);
		no_wait = r;
		no_wait.waits = '0;
	endfunction : no_wait

	function automatic logic [IST_TOTAL_W-1:0] mul(input logic [IST_CNT_W-1:0] n,
		input logic [5:0] c);
		mul = IST_TOTAL_W'(n * c);
	endfunction : mul

	// explicit covers every form that has no fixed entry here
	function automatic ist_counts_s form_counts(input ist_form_e f, input ist_counts_s x);
		form_counts = '0;
		unique case (f)
			IST_F_REG: form_counts.fetch = 3'h1;
			IST_F_IMM8: form_counts.fetch = 3'h1;
			IST_F_IMM16: form_counts.fetch = 3'h2;
			IST_F_IMM32: form_counts.fetch = 3'h3;
			IST_F_ANDL_REG: form_counts.fetch = 3'h2;
			IST_F_BITMEM:
			begin
				form_counts.fetch = 3'h2;
				form_counts.byte_acc = 3'h1;
			end
			IST_F_BCC8: form_counts.fetch = 3'h2;
			IST_F_EXPLICIT: form_counts = x;
		endcase
	endfunction : form_counts

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {IST_IDLE, IST_RUN, IST_DONE} ist_phase_e;

	typedef struct packed {
		ist_phase_e phase;
		logic [IST_TOTAL_W-1:0] remain;
		logic [IST_TOTAL_W-1:0] total;
	} ist_state_s;

	ist_state_s st;
	ist_state_s next_st;
	ist_counts_s cnt;
	logic [IST_TOTAL_W-1:0] base_states;

	always_comb
	begin
		// largest sum is four counts of 7 at 6 states, byte 7 at 3 and internal 7 at 1, so 196, well inside ten bits
		cnt = form_counts(form, explicit_counts);
		base_states = mul(cnt.fetch, cyc_cost(no_wait(map.fetch), IST_ACC_FETCH))
			+ mul(cnt.branch, cyc_cost(no_wait(map.branch), IST_ACC_WORD))
			+ mul(cnt.stack, cyc_cost(no_wait(map.stack), IST_ACC_WORD))
			+ mul(cnt.byte_acc, cyc_cost(no_wait(map.data), IST_ACC_BYTE))
			+ mul(cnt.word_acc, cyc_cost(no_wait(map.data), IST_ACC_WORD))
			+ mul(cnt.internal, {2'h0, IST_S_INTERNAL});
	end

	always_comb
	begin
		next_st = st;
		unique case (st.phase)
			IST_IDLE, IST_DONE:
			begin
				next_st.phase = IST_IDLE;
				if (start)
				begin
					next_st.phase = IST_RUN;
					next_st.remain = base_states;
					next_st.total = base_states;
				end
			end
			IST_RUN:
			begin
				// a wait stretches the running instruction by one state
				if (wait_pulse)
					next_st.total = st.total + 1'b1;
				else if (st.remain <= 1)
					next_st.phase = IST_DONE;
				else
					next_st.remain = st.remain - 1'b1;
			end
			// code 3 is never loaded; fall back to idle rather than lock up
			default: next_st.phase = IST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			st <= '{phase: IST_IDLE, remain: '0, total: '0};
		else if (clk_en)
			st <= next_st;
	end

	// ready also in the done cycle, so instructions can run back to back
	assign ready = (st.phase != IST_RUN);
	assign busy = (st.phase == IST_RUN);
	assign done = (st.phase == IST_DONE);
	assign total_states = st.total;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_start_loads_total: assert property (@(posedge clk_sys) disable iff (reset)
		(ready && start && clk_en) |=> (total_states == $past(base_states)))
		else $error("total not loaded from computed sum");
	chk_bcc_two_fetch: assert property (@(posedge clk_sys) disable iff (reset)
		(form == IST_F_BCC8 && map.fetch.region == IST_RGN_ONCHIP) |-> (base_states == 10'h004))
		else $error("short branch on chip not four states");
	chk_bitmem_mod8: assert property (@(posedge clk_sys) disable iff (reset)
		(form == IST_F_BITMEM && map.fetch.region == IST_RGN_MOD8
		&& map.data.region == IST_RGN_MOD8) |-> (base_states == 10'h00F))
		else $error("bit memory on 8-bit module not fifteen states");
	chk_imm32_ext16: assert property (@(posedge clk_sys) disable iff (reset)
		(form == IST_F_IMM32 && map.fetch.region == IST_RGN_EXT16
		&& !map.fetch.three_state) |-> (base_states == 10'h006))
		else $error("long immediate two-state 16-bit not six states");
	chk_imm16_ext8: assert property (@(posedge clk_sys) disable iff (reset)
		(form == IST_F_IMM16 && map.fetch.region == IST_RGN_EXT8
		&& map.fetch.three_state) |-> (base_states == 10'h00C))
		else $error("three-state 8-bit fetch cost wrong");
	chk_run_holds: assert property (@(posedge clk_sys) disable iff (reset)
		(ready && start && clk_en && base_states == 10'h002) |=> !ready ##1 !ready)
		else $error("next start allowed early");
	chk_run_length: assert property (@(posedge clk_sys) disable iff (reset)
		(ready && start && clk_en && base_states == 10'h003) ##1 (clk_en && !wait_pulse)[*3]
		|=> done)
		else $error("run did not end after its states");
	chk_wait_extends: assert property (@(posedge clk_sys) disable iff (reset)
		(busy && wait_pulse && clk_en) |=> (busy && total_states == $past(total_states) + 1'b1))
		else $error("wait state not added");
	// a frozen cycle must not count toward the run or take a wait
	chk_freeze: assert property (@(posedge clk_sys) disable iff (reset)
		!clk_en |=> $stable(st))
		else $error("state moved while clock enable low");
	chk_done_one_cycle: assert property (@(posedge clk_sys) disable iff (reset)
		(done && clk_en) |=> !done)
		else $error("done stood longer than one cycle");
	chk_idle_holds_total: assert property (@(posedge clk_sys) disable iff (reset)
		(ready && !start) |=> (total_states == $past(total_states)))
		else $error("total changed with no instruction taken");
	chk_mod16_fetch: assert property (@(posedge clk_sys) disable iff (reset)
		(form == IST_F_REG && map.fetch.region == IST_RGN_MOD16)
		|-> (base_states == 10'h003))
		else $error("16-bit module fetch not three states");
	chk_ext8_byte: assert property (@(posedge clk_sys) disable iff (reset)
		(form == IST_F_BITMEM && map.fetch.region == IST_RGN_ONCHIP
		&& map.data.region == IST_RGN_EXT8 && map.data.three_state) |-> (base_states == 10'h007))
		else $error("three-state 8-bit byte access cost wrong");

	cov_bcc: cover property (@(posedge clk_sys) disable iff (reset) start && form == IST_F_BCC8);
	cov_wait: cover property (@(posedge clk_sys) disable iff (reset) busy && wait_pulse);
	cov_done: cover property (@(posedge clk_sys) disable iff (reset) done ##1 busy);
	cov_back_to_back: cover property (@(posedge clk_sys) disable iff (reset) done && start && clk_en);
	cov_explicit: cover property (@(posedge clk_sys) disable iff (reset)
		start && ready && form == IST_F_EXPLICIT);

endmodule : ist_timing

// [ist_bus_model.sv]
/*
 ist_bus_model: far-side bus that inserts wait states as pulses.
 assumes the bench names the wait count at each accepted request.
*/
`timescale 1ns/1ps
module ist_bus_model
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic take,
	input wire logic [2:0] waits,
	input wire logic busy,
	output logic wait_pulse
);
	logic [2:0] left;
	// waits come back to back, so a slow bus is just a long stretch
	assign wait_pulse = busy && (left != 3'h0);
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			left <= 3'h0;
		else if (clk_en && take)
			left <= waits;
		else if (clk_en && wait_pulse)
			left <= left - 3'h1;
	end
endmodule : ist_bus_model

// [tb.sv]
/*
 tb: drives instruction timing requests and checks totals and lengths.
 assumes ist_timing and ist_bus_model compile beside it.
*/
`timescale 1ns/1ps
module tb;
	import ist_pkg::*;
	logic clk_sys, reset, clk_en, start, wait_pulse, ready, busy, done, en_rand, inrun;
	ist_form_e form;
	ist_counts_s explicit_counts;
	ist_map_s map;
	logic [IST_TOTAL_W-1:0] total_states;
	logic [2:0] waits;
	int seed = 39, num_errors = 0, cmp_count = 0, cyc = 0, len = 0, f;
	logic [IST_TOTAL_W-1:0] q_total[$];
	int q_len[$];
	ist_timing u_ist_timing (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
		.start(start), .form(form), .explicit_counts(explicit_counts), .map(map),
		.wait_pulse(wait_pulse), .ready(ready), .busy(busy), .done(done),
		.total_states(total_states));
	ist_bus_model u_ist_bus_model (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
		.take(start && ready), .waits(waits), .busy(busy), .wait_pulse(wait_pulse));
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// ----------------------------------------------------------------
	// expected cost model
	// ----------------------------------------------------------------
	function automatic logic [3:0] cost(ist_region_s r, logic by);
		case (r.region)
			IST_RGN_ONCHIP: return IST_S_ONCHIP_FETCH;
			IST_RGN_MOD8: return by ? IST_S_MOD8_BYTE : IST_S_MOD8_WORD;
			IST_RGN_MOD16: return IST_S_MOD16_WORD;
			IST_RGN_EXT8: return r.three_state ? (by ? IST_S_EXT8_3ST_BYTE :
				IST_S_EXT8_3ST_WORD) : (by ? IST_S_EXT8_2ST_BYTE : IST_S_EXT8_2ST_WORD);
			default: return r.three_state ? IST_S_EXT16_3ST_WORD : IST_S_EXT16_2ST_WORD;
		endcase
	endfunction : cost
	function automatic ist_region_s rgn(int n);
		ist_region_s r;
		r = ist_region_s'(7'($random(seed)));
		r.region = ist_region_e'(3'({$random(seed)} % n));
		return r;
	endfunction : rgn
	function automatic ist_region_s rs(ist_region_e e, logic t);
		return '{region: e, three_state: t, waits: 3'h0};
	endfunction : rs
	task automatic issue(ist_form_e fm, ist_counts_s ec, ist_map_s m, logic [2:0] nw);
		ist_counts_s c;
		logic [IST_TOTAL_W-1:0] b;
		c = '0;
		case (fm)
			IST_F_REG, IST_F_IMM8: c.fetch = 3'h1;
			IST_F_IMM16, IST_F_ANDL_REG, IST_F_BCC8: c.fetch = 3'h2;
			IST_F_IMM32: c.fetch = 3'h3;
			IST_F_BITMEM: c = '{fetch: 3'h2, byte_acc: 3'h1, default: 3'h0};
			default: c = ec;
		endcase
		b = 10'(c.fetch) * 10'(cost(m.fetch, 1'b0)) + 10'(c.branch) * 10'(cost(m.branch, 1'b0))
			+ 10'(c.stack) * 10'(cost(m.stack, 1'b0))
			+ 10'(c.internal) * 10'(IST_S_INTERNAL)
			+ 10'(c.byte_acc) * 10'(cost(m.data, 1'b1)) + 10'(c.word_acc) * 10'(cost(m.data, 1'b0));
		@(posedge clk_sys);
		#1;
		start = 1'b1;
		form = fm;
		explicit_counts = ec;
		map = m;
		waits = nw;
		q_total.push_back(b + 10'(nw));
		q_len.push_back(((b == '0) ? 1 : int'(b)) + int'(nw));
		do
			@(posedge clk_sys);
		while (!(clk_en && ready));
	endtask : issue
	// ----------------------------------------------------------------
	// checking
	// ----------------------------------------------------------------
	task automatic cmp_total(logic [IST_TOTAL_W-1:0] e);
		cmp_count++;
		if (total_states !== e)
		begin
			num_errors++;
			$display("unexpected %0t total %0d want %0d", $time, total_states, e);
		end
	endtask : cmp_total
	task automatic cmp_len(int e);
		cmp_count++;
		if (len != e + 1)
		begin
			num_errors++;
			$display("unexpected %0t length %0d want %0d", $time, len - 1, e);
		end
	endtask : cmp_len
	task automatic cmp_busy(logic e);
		cmp_count++;
		if (busy !== e)
		begin
			num_errors++;
			$display("unexpected %0t busy %b want %b", $time, busy, e);
		end
	endtask : cmp_busy
	task automatic print_verdict();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	// start held high while busy must not add a result; the queue catches it
	always @(posedge clk_sys)
	begin
		cyc++;
		if (!reset && clk_en)
		begin
			len++;
			if (done && q_total.size() == 0)
			begin
				num_errors++;
				$display("unexpected %0t result with no request", $time);
			end
			else if (done)
			begin
				cmp_total(q_total.pop_front());
				cmp_len(q_len.pop_front());
			end
			if (done)
				inrun = 1'b0;
			cmp_busy(inrun);
			if (start && ready)
			begin
				len = 0;
				inrun = 1'b1;
			end
		end
		else if (reset)
			inrun = 1'b0;
		if (cyc == 40000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	always @(posedge clk_sys)
		#1 clk_en = !en_rand || (2'($random(seed)) != 2'h0);
	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		en_rand = 1'b0;
		start = 1'b0;
		form = IST_F_REG;
		explicit_counts = '0;
		map = '0;
		waits = 3'h0;
		repeat (6) @(posedge clk_sys);
		#1 reset = 1'b0;
		for (f = 0; f < 7; f++)
			issue(ist_form_e'(f), '0, '0, 3'h0);
		issue(IST_F_EXPLICIT, '0, '0, 3'h2);
		issue(IST_F_REG, '0, {rs(IST_RGN_MOD16, 1'b0), 21'h0}, 3'h0);
		issue(IST_F_BITMEM, '0, {rs(IST_RGN_MOD8, 1'b0), 14'h0, rs(IST_RGN_MOD8, 1'b0)}, 3'h1);
		issue(IST_F_IMM32, '0, {rs(IST_RGN_EXT16, 1'b0), 21'h0}, 3'h0);
		issue(IST_F_IMM16, '0, {rs(IST_RGN_EXT8, 1'b1), 21'h0}, 3'h3);
		issue(IST_F_BITMEM, '0, {21'h0, rs(IST_RGN_EXT8, 1'b1)}, 3'h2);
		en_rand = 1'b1;
		repeat (80)
			issue(ist_form_e'(3'($random(seed))), ist_counts_s'(18'($random(seed))),
				{rgn(5), rgn(5), rgn(5), rgn(4)}, 3'($random(seed)));
		@(posedge clk_sys);
		#1 start = 1'b0;
		repeat (600) @(posedge clk_sys);
		if (q_total.size() != 0)
		begin
			num_errors++;
			$display("unexpected %0t results missing", $time);
		end
		print_verdict();
	end
endmodule : tb
